// ---- design/anrb_defines.svh ----
// anrb_defines.svh: register numbers, field values and timing figures of one actuator node bank.
// assumes a 40 MHz system clock and zero-based protocol register addresses.
`ifndef ANRB_DEFINES_SVH
`define ANRB_DEFINES_SVH

// node window: twenty registers, node n starting at twenty times (n - 1)
`define ANRB_REGS_PER_NODE  16'h0014

// register numbers inside a node window, counted from one
`define ANRB_REG_OVERRIDE   5'h02
`define ANRB_REG_COMMAND    5'h03
`define ANRB_REG_POSITION   5'h04
`define ANRB_REG_FLOW       5'h05
`define ANRB_REG_STATUS     5'h06
`define ANRB_REG_SENSOR_K   5'h07
`define ANRB_REG_SENSOR_V   5'h08
`define ANRB_REG_SERIAL1    5'h09
`define ANRB_REG_SERIAL2    5'h0a
`define ANRB_REG_SERIAL4    5'h0b
`define ANRB_REG_ACT_KIND   5'h0c
`define ANRB_REG_TIME_MON   5'h0d
`define ANRB_REG_FIRST      5'h01

// protocol function and exception codes
`define ANRB_FN_READ        8'h03
`define ANRB_FN_WRITE       8'h06
`define ANRB_EXC_NONE       8'h00
`define ANRB_EXC_FUNC       8'h01
`define ANRB_EXC_ADDR       8'h02
`define ANRB_EXC_VALUE      8'h03

// value limits and fixed read values
`define ANRB_OVR_MAX        16'h0006
`define ANRB_CMD_MAX        16'h0004
`define ANRB_SENSOR_MAX     16'h0004
`define ANRB_POS_FULL       16'h2710
`define ANRB_FLOW_NONE      16'hffff
`define ANRB_ZERO16         16'h0000

// malfunction bits that a reset command leaves alone (0 and 4), and the unused bit 3
`define ANRB_MALF_KEEP      8'h11
`define ANRB_MALF_UNUSED    8'h08

// timing, in seconds and in nanoseconds
`define ANRB_RENEW_SEC      8'h78
`define ANRB_LOST_SEC       8'h0a
`define ANRB_CLK_PERIOD_NS  25
`define ANRB_SEC_NS         1000000000

`endif

// ---- design/anrb_down_timer.sv ----
// anrb_down_timer: loadable seconds counter that stops at zero.
// assumes tick is a one-cycle pulse per second on the same clock.
`timescale 1ns/10ps
module anrb_down_timer #(
	parameter int W = 8
)(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         run,
	input  wire logic         tick,
	output logic      [W-1:0] count,
	output logic              zero
);
	assign zero = (count == '0);

	// load beats the tick so a renewal never loses a second
	always_ff @(posedge clk)
	begin
		if (rst)
			count <= '0;
		else if (load)
			count <= load_val;
		else if (run && tick && !zero)
			count <= count - 1'b1;
	end

	a_timer_load: assert property (@(posedge clk) disable iff (rst) load |=> count == $past(load_val))
		else $error("down timer missed its load");
	a_timer_hold: assert property (@(posedge clk) disable iff (rst) (!load && !(run && tick)) |=> $stable(count))
		else $error("down timer moved without a tick");
endmodule : anrb_down_timer

// ---- design/anrb_node_bank.sv ----
// anrb_node_bank: register bank of one actuator node behind a protocol-to-field-bus gateway.
// assumes a register access engine on CLK_SYS and an actuator polling engine on CLK_SYS.
`timescale 1ns/10ps
`include "anrb_defines.svh"
module anrb_node_bank import anrb_pkg::*; #(
	parameter int NODE_NUM    = 1,
	parameter int TICK_CYCLES = `ANRB_SEC_NS / `ANRB_CLK_PERIOD_NS
)(
	input  wire logic        CLK_SYS,
	input  wire logic        SYS_RST,
	input  wire logic        REG_REQ,
	input  wire logic [7:0]  REG_FUNC,
	input  wire logic [15:0] REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	output logic             REG_ACK,
	output logic             REG_EXC,
	output logic      [7:0]  REG_EXC_CODE,
	output logic      [15:0] REG_RDATA,
	input  wire logic        ACT_POLL_DONE,
	input  wire logic        ACT_POLL_OK,
	input  wire logic        ACT_NO_RESP,
	input  wire logic        ACT_CSUM_ERR,
	input  wire logic        ACT_ERR_MSG,
	input  wire logic [2:0]  ACT_TYPE,
	input  wire logic [15:0] ACT_POSITION,
	input  wire logic [15:0] ACT_FLOW,
	input  wire logic [7:0]  ACT_MALF,
	input  wire logic [15:0] ACT_SENSOR,
	input  wire logic [15:0] ACT_SERIAL1,
	input  wire logic [15:0] ACT_SERIAL2,
	input  wire logic [15:0] ACT_SERIAL4,
	output logic      [2:0]  OVR_MODE,
	output logic             OVR_SAFETY,
	output logic             CMD_STROBE,
	output logic      [2:0]  CMD_CODE,
	output logic      [2:0]  SENSOR_KIND,
	output logic             NODE_PRESENT
);
	localparam logic [15:0] BASE = 16'(`ANRB_REGS_PER_NODE * (NODE_NUM - 1));

	logic [2:0]  ovr;
	logic [2:0]  cmd;
	logic [2:0]  act_kind;
	logic [7:0]  malf;
	logic [15:0] pos;
	logic [15:0] flow;
	logic [15:0] sensor_val;
	logic [15:0] serial1;
	logic [15:0] serial2;
	logic [15:0] serial4;
	logic        err_no_resp;
	logic        err_csum;
	logic        err_msg;
	logic        err_range;
	logic        err_func;
	logic        expired;
	logic        sec_tick;
	logic [7:0]  remain;
	logic        remain_zero;
	logic        lost_zero;

	wire [15:0] rel     = REG_ADDR - BASE;
	wire        in_win  = (REG_ADDR >= BASE) && (rel < `ANRB_REGS_PER_NODE);
	wire [4:0]  reg_num = rel[4:0] + `ANRB_REG_FIRST;
	wire        take    = REG_REQ && in_win;
	wire        is_rd   = (REG_FUNC == `ANRB_FN_READ);
	wire        is_wr   = (REG_FUNC == `ANRB_FN_WRITE);

	// write checks per register
	wire sel_ovr  = (reg_num == `ANRB_REG_OVERRIDE);
	wire sel_cmd  = (reg_num == `ANRB_REG_COMMAND);
	wire sel_sns  = (reg_num == `ANRB_REG_SENSOR_K);
	wire writable = sel_ovr || sel_cmd || sel_sns;
	wire is_fire  = (act_kind == ACT_FIRE_DAMPER);
	wire is_cmpct = (act_kind == ACT_COMPACT);
	// fire dampers refuse all but open and fast close
	wire fire_ok  = (REG_WDATA == 16'(OVR_OPEN)) || (REG_WDATA == 16'(OVR_FAST_CLOSE));
	wire ovr_ok   = (REG_WDATA <= `ANRB_OVR_MAX) && (!is_fire || fire_ok);
	wire cmd_na   = is_cmpct && (REG_WDATA <= `ANRB_CMD_MAX) && (REG_WDATA != 16'(CMD_NONE))
	                && (REG_WDATA != 16'(CMD_ADAPTION));
	wire cmd_ok   = (REG_WDATA <= `ANRB_CMD_MAX) && !cmd_na;
	wire sns_ok   = (REG_WDATA <= `ANRB_SENSOR_MAX);
	wire val_ok   = sel_ovr ? ovr_ok : (sel_cmd ? cmd_ok : sns_ok);
	wire wr_good  = take && is_wr && writable && val_ok;
	wire wr_ovr   = wr_good && sel_ovr;
	wire wr_cmd   = wr_good && sel_cmd;
	wire wr_sns   = wr_good && sel_sns;
	wire bad_val  = take && is_wr && writable && !val_ok;

	// exception selection, function first, then address, then value
	wire [7:0] exc_sel = !(is_rd || is_wr)        ? `ANRB_EXC_FUNC :
	                     (is_wr && !writable)      ? `ANRB_EXC_ADDR :
	                     (is_wr && !val_ok)        ? `ANRB_EXC_VALUE : `ANRB_EXC_NONE;

	wire [7:0]  malf_shown = is_cmpct ? 8'h00 : malf;
	// low byte malfunctions, high byte gateway errors
	wire [15:0] status = {2'b00, expired, err_func, err_range, err_msg, err_csum, err_no_resp, malf_shown};
	// flow only meaningful for flow controllers
	wire [15:0] flow_rd = (act_kind == ACT_FLOW_CTRL) ? flow : `ANRB_FLOW_NONE;
	// no reading without a selected sensor kind
	wire [15:0] sns_rd  = (SENSOR_KIND == SNS_NONE) ? `ANRB_ZERO16 : sensor_val;

	// read mux, register 13 is the renewal time; unused numbers read zero
	wire [15:0] rd_val = (reg_num == `ANRB_REG_OVERRIDE) ? 16'(ovr) :
	                     (reg_num == `ANRB_REG_COMMAND)  ? 16'(cmd) :
	                     (reg_num == `ANRB_REG_POSITION) ? pos :
	                     (reg_num == `ANRB_REG_FLOW)     ? flow_rd :
	                     (reg_num == `ANRB_REG_STATUS)   ? status :
	                     (reg_num == `ANRB_REG_SENSOR_K) ? 16'(SENSOR_KIND) :
	                     (reg_num == `ANRB_REG_SENSOR_V) ? sns_rd :
	                     (reg_num == `ANRB_REG_SERIAL1)  ? serial1 :
	                     (reg_num == `ANRB_REG_SERIAL2)  ? serial2 :
	                     (reg_num == `ANRB_REG_SERIAL4)  ? serial4 :
	                     (reg_num == `ANRB_REG_ACT_KIND) ? 16'(act_kind) :
	                     (reg_num == `ANRB_REG_TIME_MON) ? 16'(remain) : `ANRB_ZERO16;

	// register access answer, one cycle after the request
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			REG_ACK      <= 1'b0;
			REG_EXC      <= 1'b0;
			REG_EXC_CODE <= `ANRB_EXC_NONE;
			REG_RDATA    <= `ANRB_ZERO16;
		end
		else
		begin
			REG_ACK      <= take;
			REG_EXC      <= take && (exc_sel != `ANRB_EXC_NONE);
			REG_EXC_CODE <= take ? exc_sel : `ANRB_EXC_NONE;
			REG_RDATA    <= (take && is_rd) ? rd_val : (take && is_wr) ? REG_WDATA : `ANRB_ZERO16;
		end
	end

	// override code store, sensor kind store
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			ovr         <= OVR_NONE;
			SENSOR_KIND <= SNS_NONE;
		end
		else
		begin
			if (wr_ovr)
				ovr <= REG_WDATA[2:0];
			if (wr_sns)
				SENSOR_KIND <= REG_WDATA[2:0];
		end
	end

	// command is held one cycle as the strobe, then cleared
	assign CMD_STROBE = (cmd != CMD_NONE);
	assign CMD_CODE   = cmd;
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			cmd <= CMD_NONE;
		else if (wr_cmd)
			cmd <= REG_WDATA[2:0];
		else
			cmd <= CMD_NONE;
	end

	// reset command spares bits 0 and 4; new flags win over the clear
	wire       poll_ok   = ACT_POLL_DONE && ACT_POLL_OK;
	wire       malf_clr  = CMD_STROBE && (cmd == CMD_RESET_MALF);
	wire [7:0] keep_mask = malf_clr ? `ANRB_MALF_KEEP : 8'hff;
	wire [7:0] next_malf = ((malf & keep_mask) | (poll_ok ? ACT_MALF : 8'h00)) & ~`ANRB_MALF_UNUSED;

	// actuator data taken on each good exchange
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			malf       <= 8'h00;
			pos        <= `ANRB_ZERO16;
			flow       <= `ANRB_ZERO16;
			sensor_val <= `ANRB_ZERO16;
			serial1    <= `ANRB_ZERO16;
			serial2    <= `ANRB_ZERO16;
			serial4    <= `ANRB_ZERO16;
		end
		else
		begin
			malf <= next_malf;
			if (poll_ok)
			begin
				pos        <= (ACT_POSITION > `ANRB_POS_FULL) ? `ANRB_POS_FULL : ACT_POSITION;
				// flow already scaled to nominal flow or pressure
				flow       <= ACT_FLOW;
				sensor_val <= ACT_SENSOR;
				// serial parts one, two and four
				serial1    <= ACT_SERIAL1;
				serial2    <= ACT_SERIAL2;
				serial4    <= ACT_SERIAL4;
			end
		end
	end

	// gateway errors cleared by hardware only
	// exchange errors follow the latest exchange; write errors end on a good one
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			err_no_resp <= 1'b0;
			err_csum    <= 1'b0;
			err_msg     <= 1'b0;
			err_range   <= 1'b0;
			err_func    <= 1'b0;
		end
		else
		begin
			if (ACT_POLL_DONE)
			begin
				err_no_resp <= ACT_NO_RESP;
				err_csum    <= ACT_CSUM_ERR;
				err_msg     <= ACT_ERR_MSG;
			end
			err_range <= (bad_val && !cmd_na) || (err_range && !poll_ok);
			err_func  <= (bad_val && sel_cmd && cmd_na) || (err_func && !poll_ok);
		end
	end

	anrb_sec_tick #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.clk  (CLK_SYS),
		.rst  (SYS_RST),
		.tick (sec_tick)
	);

	// renewal countdown only for a fire damper held open
	wire wd_active = is_fire && (ovr == OVR_OPEN) && !expired;

	// each override write reloads 120 s
	anrb_down_timer #(
		.W (8)
	) u_renew (
		.clk      (CLK_SYS),
		.rst      (SYS_RST),
		.load     (wr_ovr),
		.load_val (`ANRB_RENEW_SEC),
		.run      (wd_active),
		.tick     (sec_tick),
		.count    (remain),
		.zero     (remain_zero)
	);

	// timeout latches until the override is written again
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			expired <= 1'b0;
		else
			expired <= !wr_ovr && (expired || (wd_active && remain_zero));
	end

	// safety position replaces the override on timeout
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
		begin
			OVR_MODE   <= OVR_NONE;
			OVR_SAFETY <= 1'b0;
		end
		else
		begin
			OVR_MODE   <= expired ? OVR_FAST_CLOSE : ovr;
			OVR_SAFETY <= expired;
		end
	end

	// silence timer reloaded by each good exchange
	anrb_down_timer #(
		.W (8)
	) u_lost (
		.clk      (CLK_SYS),
		.rst      (SYS_RST),
		.load     (poll_ok),
		.load_val (`ANRB_LOST_SEC),
		.run      (NODE_PRESENT),
		.tick     (sec_tick),
		.count    (),
		.zero     (lost_zero)
	);

	// kind from the actuator; dropped after silence
	always_ff @(posedge CLK_SYS)
	begin
		if (SYS_RST)
			act_kind <= ACT_NONE;
		else if (poll_ok)
			act_kind <= ACT_TYPE;
		else if (lost_zero)
			act_kind <= ACT_NONE;
	end
	assign NODE_PRESENT = (act_kind != ACT_NONE);

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);

	sequence s_last_second;
		wd_active && remain_zero;
	endsequence
	sequence s_safety_out;
		expired ##1 (OVR_SAFETY && OVR_MODE == OVR_FAST_CLOSE);
	endsequence

	a_cmd_one_shot: assert property (CMD_STROBE && !wr_cmd |=> !CMD_STROBE && cmd == CMD_NONE)
		else $error("command not cleared after one strobe");
	a_cmd_code_range: assert property (CMD_STROBE |-> CMD_CODE <= 3'(`ANRB_CMD_MAX))
		else $error("command code outside its set");
	a_compact_adapt: assert property ($rose(CMD_STROBE) && is_cmpct && $past(is_cmpct) |-> CMD_CODE == CMD_ADAPTION)
		else $error("compact actuator got a non adaption command");
	a_flow_blank: assert property (take && is_rd && reg_num == `ANRB_REG_FLOW && act_kind != ACT_FLOW_CTRL
		|=> REG_RDATA == `ANRB_FLOW_NONE)
		else $error("relative flow not blanked");
	a_pos_limit: assert property (pos <= `ANRB_POS_FULL)
		else $error("position above full travel");
	a_compact_quiet: assert property (take && is_rd && reg_num == `ANRB_REG_STATUS && is_cmpct
		|=> REG_RDATA[7:0] == 8'h00)
		else $error("compact actuator shows malfunctions");
	a_malf_reset: assert property (malf_clr && !poll_ok |=> malf[3:1] == 3'b000 && malf[7:5] == 3'b000
		&& malf[0] == $past(malf[0]) && malf[4] == $past(malf[4]))
		else $error("reset command cleared wrong malfunction bits");
	a_renew_reload: assert property (wr_ovr |=> remain == `ANRB_RENEW_SEC && !expired)
		else $error("override write did not reload renewal time");
	a_renew_expire: assert property (s_last_second and !wr_ovr |=> s_safety_out)
		else $error("renewal timeout did not reach safety position");
	a_node_drop: assert property (lost_zero && NODE_PRESENT && !poll_ok |=> act_kind == ACT_NONE)
		else $error("silent node not dropped");
	a_func_only: assert property (REG_ACK && !REG_EXC |-> $past(is_rd) || $past(is_wr))
		else $error("unsupported function answered without exception");
endmodule : anrb_node_bank

// ---- design/anrb_pkg.sv ----
// anrb_pkg: code types of the actuator node bank.
// assumes anrb_defines.svh is compiled alongside.
package anrb_pkg;

	typedef enum logic [2:0] {
		OVR_NONE = 3'b000, OVR_OPEN = 3'b001, OVR_CLOSED = 3'b010, OVR_MIN = 3'b011,
		OVR_MID = 3'b100, OVR_MAX = 3'b101, OVR_FAST_CLOSE = 3'b110
	} anrb_override_t;

	typedef enum logic [2:0] {
		CMD_NONE = 3'b000, CMD_ADAPTION = 3'b001, CMD_TEST_RUN = 3'b010,
		CMD_SYNC = 3'b011, CMD_RESET_MALF = 3'b100
	} anrb_command_t;

	typedef enum logic [2:0] {
		ACT_NONE = 3'b000, ACT_AIR_WATER = 3'b001, ACT_VALVE_LIN = 3'b010, ACT_VALVE_ROT = 3'b011,
		ACT_FIRE_DAMPER = 3'b100, ACT_FLOW_CTRL = 3'b101, ACT_COMPACT = 3'b110
	} anrb_act_kind_t;

	typedef enum logic [2:0] {
		SNS_NONE = 3'b000, SNS_ACTIVE_MV = 3'b001, SNS_PASSIVE_1K = 3'b010,
		SNS_PASSIVE_120K = 3'b011, SNS_SWITCH = 3'b100
	} anrb_sensor_t;

endpackage : anrb_pkg

// ---- design/anrb_sec_tick.sv ----
// anrb_sec_tick: one-cycle pulse once per second from the system clock.
// assumes CYCLES is the number of system clocks in one second.
`timescale 1ns/10ps
module anrb_sec_tick #(
	parameter int CYCLES = 40000000
)(
	input  wire logic clk,
	input  wire logic rst,
	output logic      tick
);
	localparam int CW = $clog2(CYCLES);
	logic [CW-1:0] cnt;
	wire           wrap = (cnt == CW'(CYCLES - 1));

	// free-running divider, so every timer in the bank shares one seconds grid
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt  <= '0;
			tick <= 1'b0;
		end
		else
		begin
			cnt  <= wrap ? '0 : cnt + 1'b1;
			tick <= wrap;
		end
	end

	a_tick_spacing: assert property (@(posedge clk) disable iff (rst) tick |-> cnt == '0)
		else $error("seconds tick off the divider wrap");
endmodule : anrb_sec_tick

// ---- verification/actuator_node_register_bank_tb_top.sv ----
// actuator_node_register_bank_tb_top: scenario bench for one node bank with a modelled actuator.
// assumes node two (window from register twenty) and an eight-cycle seconds tick.
`timescale 1ns/10ps
`include "anrb_defines.svh"
module actuator_node_register_bank_tb_top import anrb_pkg::*;;
	localparam logic [15:0] BASE = 16'h0014;
	localparam logic [15:0] POS  = 16'h2710;
	localparam logic [15:0] FLOW = 16'h1388;
	localparam logic [15:0] SENS = 16'h0321;
	localparam logic [15:0] SER1 = 16'h0347;
	localparam logic [15:0] SER2 = 16'h7a3c;
	localparam logic [15:0] SER4 = 16'h0008;
	logic        clk = 1'b0, rst = 1'b1, req = 1'b0, poll_en = 1'b0;
	logic [7:0]  func = 8'h00, malf = 8'h00, exc_code, a_malf;
	logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, a_pos, a_flow, a_sens, s1, s2, s4, rd, r1;
	logic [1:0]  err_kind = 2'h0;
	logic [2:0]  kind = 3'h0, a_type, ovr_mode, cmd_code, sensor_kind, stb_code;
	logic        ack, exc, done, ok, no_resp, csum_err, err_msg, ovr_safety, cmd_strobe, node_present, stb_seen;
	int          fail_count = 0, total_checks = 0, cyc = 0, t0;

	// clock and cycle count
	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	anrb_node_bank #(.NODE_NUM(2), .TICK_CYCLES(8)) anrb_node_bank_i (.CLK_SYS(clk), .SYS_RST(rst),
		.REG_REQ(req), .REG_FUNC(func), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_ACK(ack), .REG_EXC(exc),
		.REG_EXC_CODE(exc_code), .REG_RDATA(rdata), .ACT_POLL_DONE(done), .ACT_POLL_OK(ok),
		.ACT_NO_RESP(no_resp), .ACT_CSUM_ERR(csum_err), .ACT_ERR_MSG(err_msg), .ACT_TYPE(a_type),
		.ACT_POSITION(a_pos), .ACT_FLOW(a_flow), .ACT_MALF(a_malf), .ACT_SENSOR(a_sens), .ACT_SERIAL1(s1),
		.ACT_SERIAL2(s2), .ACT_SERIAL4(s4), .OVR_MODE(ovr_mode), .OVR_SAFETY(ovr_safety),
		.CMD_STROBE(cmd_strobe), .CMD_CODE(cmd_code), .SENSOR_KIND(sensor_kind), .NODE_PRESENT(node_present));

	anrb_actuator_model #(.POS(POS), .FLOW(FLOW), .SENS(SENS), .SER1(SER1), .SER2(SER2), .SER4(SER4))
		anrb_actuator_model_i (.clk(clk), .rst(rst), .poll_en(poll_en), .err_kind(err_kind), .kind(kind),
		.malf(malf), .done(done), .ok(ok), .no_resp(no_resp), .csum_err(csum_err), .err_msg(err_msg),
		.act_type(a_type), .position(a_pos), .flow(a_flow), .malf_out(a_malf), .sensor(a_sens),
		.serial1(s1), .serial2(s2), .serial4(s4));

	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_cyc

	// one request held over one edge; the answer stands only in the next cycle
	task automatic reg_op(input logic [7:0] fn, input logic [4:0] num, input logic [15:0] wd, input logic [7:0] ex);
		req   = 1'b1;
		func  = fn;
		addr  = BASE + {11'h000, num} - 16'h0001;
		wdata = wd;
		wait_cyc(1);
		req      = 1'b0;
		rd       = rdata;
		stb_seen = cmd_strobe;
		stb_code = cmd_code;
		chk({15'h0000, ack}, 16'h0001);
		chk({8'h00, exc_code}, {8'h00, ex});
		chk({15'h0000, exc}, {15'h0000, ex != 8'h00});
		// let an edge pass so the next request never re-raises req in this time step
		wait_cyc(1);
	endtask : reg_op

	task automatic rd_chk(input logic [4:0] num, input logic [15:0] exp);
		reg_op(`ANRB_FN_READ, num, 16'h0000, `ANRB_EXC_NONE);
		chk(rd, exp);
	endtask : rd_chk

	task automatic wr(input logic [4:0] num, input logic [15:0] v, input logic [7:0] ex);
		reg_op(`ANRB_FN_WRITE, num, v, ex);
	endtask : wr

	task automatic t_basic();
		chk({15'h0000, node_present}, 16'h0000);
		rd_chk(5'h02, 16'h0000);
		rd_chk(5'h0c, 16'h0000);
		reg_op(8'h04, 5'h02, 16'h0000, `ANRB_EXC_FUNC);
		reg_op(8'h10, 5'h02, 16'h0001, `ANRB_EXC_FUNC);
		wr(5'h04, 16'h0001, `ANRB_EXC_ADDR);
		// addresses just outside the window get no answer at all
		for (int i = 0; i < 2; i++)
		begin
			req  = 1'b1;
			addr = (i == 0) ? BASE - 16'h0001 : BASE + 16'h0014;
			wait_cyc(1);
			req = 1'b0;
			chk({15'h0000, ack}, 16'h0000);
			wait_cyc(1);
		end
		$display("test basic done");
	endtask : t_basic

	task automatic t_poll();
		kind    = ACT_FLOW_CTRL;
		poll_en = 1'b1;
		wait_cyc(30);
		chk({15'h0000, node_present}, 16'h0001);
		rd_chk(5'h04, POS);
		rd_chk(5'h05, FLOW);
		rd_chk(5'h09, SER1);
		rd_chk(5'h0a, SER2);
		rd_chk(5'h0b, SER4);
		rd_chk(5'h0c, 16'h0005);
		for (int k = 0; k <= 4; k++)
		begin
			wr(5'h07, 16'(k), `ANRB_EXC_NONE);
			chk({13'h0000, sensor_kind}, 16'(k));
			rd_chk(5'h08, (k == 0) ? 16'h0000 : SENS);
		end
		wr(5'h07, 16'h0005, `ANRB_EXC_VALUE);
		kind = ACT_AIR_WATER;
		wait_cyc(30);
		rd_chk(5'h05, `ANRB_FLOW_NONE);
		$display("test poll done");
	endtask : t_poll

	task automatic t_errors();
		for (int e = 1; e <= 3; e++)
		begin
			err_kind = 2'(e);
			wait_cyc(26);
			rd_chk(5'h06, 16'h0080 << e);
			err_kind = 2'h0;
			wait_cyc(26);
			rd_chk(5'h06, 16'h0000);
		end
		$display("test errors done");
	endtask : t_errors

	task automatic t_override();
		for (int v = 0; v <= 6; v++)
		begin
			wr(5'h02, 16'(v), `ANRB_EXC_NONE);
			wait_cyc(1);
			chk({13'h0000, ovr_mode}, 16'(v));
		end
		poll_en = 1'b0;
		wr(5'h02, 16'h0007, `ANRB_EXC_VALUE);
		chk({13'h0000, ovr_mode}, 16'h0006);
		rd_chk(5'h06, 16'h0800);
		poll_en = 1'b1;
		wait_cyc(30);
		rd_chk(5'h06, 16'h0000);
		$display("test override done");
	endtask : t_override

	task automatic t_malf();
		malf = 8'hff;
		wait_cyc(30);
		rd_chk(5'h06, 16'h00f7);
		malf = 8'h00;
		for (int c = 1; c <= 4; c++)
		begin
			wr(5'h03, 16'(c), `ANRB_EXC_NONE);
			chk({15'h0000, stb_seen}, 16'h0001);
			chk({13'h0000, stb_code}, 16'(c));
			rd_chk(5'h03, 16'h0000);
			chk({15'h0000, cmd_strobe}, 16'h0000);
		end
		rd_chk(5'h06, 16'h0011);
		$display("test malfunction done");
	endtask : t_malf

	task automatic t_compact();
		kind = ACT_COMPACT;
		malf = 8'hff;
		wait_cyc(30);
		rd_chk(5'h06, 16'h0000);
		poll_en = 1'b0;
		for (int c = 2; c <= 4; c++)
		begin
			wr(5'h03, 16'(c), `ANRB_EXC_VALUE);
			chk({15'h0000, stb_seen}, 16'h0000);
		end
		rd_chk(5'h06, 16'h1000);
		wr(5'h03, 16'h0001, `ANRB_EXC_NONE);
		chk({15'h0000, stb_seen}, 16'h0001);
		poll_en = 1'b1;
		malf    = 8'h00;
		wait_cyc(30);
		rd_chk(5'h06, 16'h0000);
		$display("test compact done");
	endtask : t_compact

	task automatic t_fire();
		kind = ACT_FIRE_DAMPER;
		wait_cyc(30);
		for (int v = 0; v <= 5; v++)
			if (v != 1)
				wr(5'h02, 16'(v), `ANRB_EXC_VALUE);
		wr(5'h02, 16'h0001, `ANRB_EXC_NONE);
		t0 = cyc;
		wait_cyc(1);
		chk({13'h0000, ovr_mode}, 16'h0001);
		reg_op(`ANRB_FN_READ, 5'h0d, 16'h0000, `ANRB_EXC_NONE);
		r1 = rd;
		chk({15'h0000, r1 >= 16'h0077 && r1 <= `ANRB_RENEW_SEC}, 16'h0001);
		wait_cyc(6);
		rd_chk(5'h0d, r1 - 16'h0001);
		while (ovr_safety !== 1'b1 && cyc - t0 < 1100)
			wait_cyc(1);
		chk({15'h0000, cyc - t0 >= 950 && cyc - t0 <= 970}, 16'h0001);
		chk({13'h0000, ovr_mode}, 16'h0006);
		rd_chk(5'h0d, 16'h0000);
		reg_op(`ANRB_FN_READ, 5'h06, 16'h0000, `ANRB_EXC_NONE);
		chk({15'h0000, rd[13]}, 16'h0001);
		wr(5'h02, 16'h0001, `ANRB_EXC_NONE);
		wait_cyc(1);
		chk({15'h0000, ovr_safety}, 16'h0000);
		reg_op(`ANRB_FN_READ, 5'h06, 16'h0000, `ANRB_EXC_NONE);
		chk({15'h0000, rd[13]}, 16'h0000);
		$display("test fire damper done");
	endtask : t_fire

	task automatic t_silence();
		poll_en = 1'b0;
		wait_cyc(40);
		chk({15'h0000, node_present}, 16'h0001);
		wait_cyc(80);
		chk({15'h0000, node_present}, 16'h0000);
		rd_chk(5'h0c, 16'h0000);
		$display("test silence done");
	endtask : t_silence

	// main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		#1;
		rst = 1'b0;
		// first request only after one edge with reset low
		wait_cyc(1);
		t_basic();
		t_poll();
		t_errors();
		t_override();
		t_malf();
		t_compact();
		t_fire();
		t_silence();
		summarize();
	end

	// watchdog well beyond the expected sixteen hundred cycles
	initial
	begin
		repeat (6000) @(posedge clk);
		fail_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		summarize();
	end
endmodule : actuator_node_register_bank_tb_top

// ---- verification/anrb_actuator_model.sv ----
// anrb_actuator_model: polling engine and field-bus actuator as seen from one node bank.
// assumes the bench sets kind, flags and exchange errors between exchanges.
`timescale 1ns/10ps
module anrb_actuator_model #(
	parameter int          PERIOD = 24,
	parameter logic [15:0] POS    = 16'h2710,
	parameter logic [15:0] FLOW   = 16'h1388,
	parameter logic [15:0] SENS   = 16'h0321,
	parameter logic [15:0] SER1   = 16'h0347,
	parameter logic [15:0] SER2   = 16'h7a3c,
	parameter logic [15:0] SER4   = 16'h0008
)(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        poll_en,
	input  wire logic [1:0]  err_kind,
	input  wire logic [2:0]  kind,
	input  wire logic [7:0]  malf,
	output logic             done,
	output logic             ok,
	output logic             no_resp,
	output logic             csum_err,
	output logic             err_msg,
	output logic      [2:0]  act_type,
	output logic      [15:0] position,
	output logic      [15:0] flow,
	output logic      [7:0]  malf_out,
	output logic      [15:0] sensor,
	output logic      [15:0] serial1,
	output logic      [15:0] serial2,
	output logic      [15:0] serial4
);
	logic [7:0]  cnt;
	logic [15:0] junk;

	// exchange spacing, and a pattern that churns every cycle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt  <= 8'h00;
			junk <= 16'h5a5a;
		end
		else
		begin
			cnt  <= (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
			junk <= ~junk ^ {8'h00, cnt};
		end
	end

	// data is unqualified outside a good exchange, so it never holds a stale value
	assign done     = poll_en & (cnt == 8'h00);
	assign ok       = done & (err_kind == 2'h0);
	assign no_resp  = done & (err_kind == 2'h1);
	assign csum_err = done & (err_kind == 2'h2);
	assign err_msg  = done & (err_kind == 2'h3);
	assign act_type = ok ? kind : junk[2:0];
	assign position = ok ? POS : junk;
	assign flow     = ok ? FLOW : ~junk;
	assign malf_out = ok ? malf : junk[7:0];
	assign sensor   = ok ? SENS : junk;
	assign serial1  = ok ? SER1 : ~junk;
	assign serial2  = ok ? SER2 : junk;
	assign serial4  = ok ? SER4 : ~junk;
endmodule : anrb_actuator_model
